// >>> core/hdcr_defs.svh
// Offsets, field positions, reset values and timing counts of the hub configuration bank
`ifndef HDCR_DEFS_SVH
`define HDCR_DEFS_SVH
`define HDCR_OFF_DEV_CFG 8'h05
`define HDCR_OFF_CHARGE 8'h06
`define HDCR_OFF_RMBL 8'h07
`define HDCR_BIT_STR_UNLOCK 7
`define HDCR_BIT_SER_UNLOCK 6
`define HDCR_BIT_LPM_OFF 5
`define HDCR_BIT_RSVD_ONE 4
`define HDCR_BIT_SHARED 3
`define HDCR_BIT_PM_OFF_N 2
`define HDCR_BIT_RSVD_RW 1
`define HDCR_BIT_RMBL_OVR 7
`define HDCR_DEV_CFG_RST 8'h10
`define HDCR_DEV_CFG_WMASK 8'hEE
`define HDCR_CHARGE_WMASK 8'h03
`define HDCR_RMBL_WMASK 8'h83
`define HDCR_STRAP_SETTLE 4'h2
`endif

// >>> core/hdcr_pkg.sv
// Types shared by the hub configuration bank
`default_nettype none
package hdcr_pkg;
  typedef enum logic [1:0] {
    HDCR_RESET,
    HDCR_SETTLE,
    HDCR_RUN
  } hdcr_phase_type;
  typedef enum logic [1:0] {
    HDCR_SRC_NONE,
    HDCR_SRC_EEPROM,
    HDCR_SRC_SMBUS
  } hdcr_src_type;
endpackage
`default_nettype wire

// >>> core/hdcr_sync2.sv
// Two-flop synchroniser for strap and pin levels
`default_nettype none
module hdcr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } hdcr_sync_type;
  hdcr_sync_type s_q;
  hdcr_sync_type s_d;

  // First stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.meta = d_i;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.stab;
endmodule
`default_nettype wire

// >>> core/hdcr_regs.sv
// Device configuration, charge enable and removable registers of a two-port hub
//
// Contract
// - Bit 7 unlocks manufacturer/product/language string writes; default 0.
// - Bit 6 unlocks serial string and its length writes; default 0.
// - Bit 5 set forbids starting or accepting U1/U2 on every port.
// - After a forced-accept LMP, U1/U2 works normally until reset or upstream disconnect.
// - Bit 4 is read only and always reads one.
// - Shared-power strap level is captured into bit 3 at reset release.
// - With management on, bit 3 picks per-port or shared port 1 switching.
// - Power-management strap is captured into bit 2 at reset release.
// - Bit 2 zero enables power switching and overcurrent report; one disables both.
// - EEPROM reloads bits 5,3,2 after reset; SMBus host may overwrite them.
// - Bit 1 reserved writable; bit 0 reserved read only zero.
// - Charge byte bits 7:2 are read only zero.
// - Charge bits 1:0 enable charging on downstream ports 1 and 2.
// - Charge bits load from the shared power/charge pins at reset release.
// - Charge bits may later be overwritten by EEPROM or SMBus host.
// - Removable bits writable only with override set; else inverted factory values.
`default_nettype none
`include "hdcr_defs.svh"
module hdcr_regs
  import hdcr_pkg::*;
#(
  parameter logic [1:0] FACTORY_FIXED = 2'b00
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic shared_power_strap_i,
  input wire logic power_mgmt_strap_i,
  input wire logic [1:0] charge_enable_pin_i,
  input wire logic eeprom_mode_i,
  input wire logic smbus_mode_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_addr_rd_i,
  input wire logic force_lpm_accept_i,
  input wire logic upstream_disconnect_i,
  input wire logic [1:0] port_power_req_i,
  input wire logic [1:0] overcurrent_i,
  output logic [7:0] cfg_rdata_o,
  output logic string_write_unlock_o,
  output logic serial_string_unlock_o,
  output logic link_lpm_allow_o,
  output logic [1:0] port_power_out_o,
  output logic [1:0] overcurrent_report_o,
  output logic [1:0] charge_port_en_o,
  output logic [1:0] port_removable_o,
  output logic strap_ready_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    hdcr_phase_type phase;
    logic [3:0] settle;
    logic [7:0] dev_cfg;
    logic [7:0] charge;
    logic [7:0] rmbl;
    logic lpm_forced;
    logic [7:0] rdata;
    logic str_unlock;
    logic ser_unlock;
    logic lpm_allow;
    logic [1:0] pwr_out;
    logic [1:0] oc_rep;
    logic [1:0] chg_out;
    logic [1:0] rmbl_out;
    logic ready;
  } hdcr_state_type;

  hdcr_state_type s_q;
  hdcr_state_type s_d;
  logic shared_sync;
  logic pm_sync;
  logic [1:0] chg_sync;
  logic host_wr;
  logic [1:0] oc_sync;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Straps are pins, so they cross two flops before being captured
  hdcr_sync2 #(.WIDTH(4)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({shared_power_strap_i, power_mgmt_strap_i, charge_enable_pin_i}),
    .q_o({shared_sync, pm_sync, chg_sync})
  );

  // Overcurrent flags come from off-chip switches, so they cross two flops as well
  hdcr_sync2 #(.WIDTH(2)) u_oc_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(overcurrent_i),
    .q_o(oc_sync)
  );

  // Merge written bits under a mask; fixed bits are pinned afterwards in the next-state logic
  function automatic logic [7:0] hdcr_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    hdcr_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Only a configuration source (EEPROM in I2C mode, host in SMBus mode) writes
  assign host_wr = cfg_wr_i && (eeprom_mode_i || smbus_mode_i) && (s_q.phase == HDCR_RUN);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    case (s_q.phase)
      HDCR_RESET: begin
        s_d.phase = HDCR_SETTLE;
        s_d.settle = `HDCR_STRAP_SETTLE;
      end
      HDCR_SETTLE: begin
        // Wait for the synchroniser to fill before sampling straps
        if (s_q.settle == 4'h0) begin
          s_d.phase = HDCR_RUN;
          s_d.dev_cfg[`HDCR_BIT_SHARED] = shared_sync;
          s_d.dev_cfg[`HDCR_BIT_PM_OFF_N] = pm_sync;
          s_d.charge[1:0] = chg_sync;
        end else begin
          s_d.settle = s_q.settle - 4'h1;
        end
      end
      default: begin
        // Register writes from EEPROM load or SMBus host
        if (host_wr) begin
          if (cfg_addr_i == `HDCR_OFF_DEV_CFG) begin
            s_d.dev_cfg = hdcr_merge(s_q.dev_cfg, cfg_wdata_i, `HDCR_DEV_CFG_WMASK);
          end else if (cfg_addr_i == `HDCR_OFF_CHARGE) begin
            s_d.charge = hdcr_merge(s_q.charge, cfg_wdata_i, `HDCR_CHARGE_WMASK);
          end else if (cfg_addr_i == `HDCR_OFF_RMBL) begin
            s_d.rmbl[`HDCR_BIT_RMBL_OVR] = cfg_wdata_i[`HDCR_BIT_RMBL_OVR];
            // Port bits follow the override in force before this write
            if (s_q.rmbl[`HDCR_BIT_RMBL_OVR]) begin
              s_d.rmbl[1:0] = cfg_wdata_i[1:0];
            end
          end
        end
      end
    endcase
    // Fixed reserved bits can never be altered
    s_d.dev_cfg[`HDCR_BIT_RSVD_ONE] = 1'b1;
    s_d.dev_cfg[0] = 1'b0;
    s_d.charge[7:2] = 6'h00;
    s_d.rmbl[6:2] = 5'h00;
    // Forced accept latches until upstream disconnect; reset clears it too.
    // A forced accept in the same cycle as a disconnect wins, so it is never lost
    if (force_lpm_accept_i) begin
      s_d.lpm_forced = 1'b1;
    end else if (upstream_disconnect_i) begin
      s_d.lpm_forced = 1'b0;
    end
    // Registered read data
    if (cfg_addr_rd_i == `HDCR_OFF_DEV_CFG) begin
      s_d.rdata = s_q.dev_cfg;
    end else if (cfg_addr_rd_i == `HDCR_OFF_CHARGE) begin
      s_d.rdata = s_q.charge;
    end else if (cfg_addr_rd_i == `HDCR_OFF_RMBL) begin
      s_d.rdata = {s_q.rmbl[7], 5'h00,
                   s_q.rmbl[7] ? s_q.rmbl[1:0] : ~FACTORY_FIXED};
    end else begin
      s_d.rdata = 8'h00;
    end
    // Outputs to the rest of the hub
    s_d.str_unlock = s_q.dev_cfg[`HDCR_BIT_STR_UNLOCK];
    s_d.ser_unlock = s_q.dev_cfg[`HDCR_BIT_SER_UNLOCK];
    s_d.lpm_allow = ~s_q.dev_cfg[`HDCR_BIT_LPM_OFF] | s_q.lpm_forced;
    // Management off: no switching, no overcurrent report
    if (s_q.dev_cfg[`HDCR_BIT_PM_OFF_N]) begin
      s_d.pwr_out = 2'b00;
      s_d.oc_rep = 2'b00;
    end else if (s_q.dev_cfg[`HDCR_BIT_SHARED]) begin
      // Shared: any request powers all ports through the port 1 output
      s_d.pwr_out = {1'b0, |port_power_req_i};
      s_d.oc_rep = {2{|oc_sync}};
    end else begin
      s_d.pwr_out = port_power_req_i;
      s_d.oc_rep = oc_sync;
    end
    s_d.chg_out = s_q.charge[1:0];
    s_d.rmbl_out = s_q.rmbl[7] ? s_q.rmbl[1:0] : ~FACTORY_FIXED;
    s_d.ready = (s_q.phase == HDCR_RUN);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.phase <= HDCR_RESET;
      s_q.dev_cfg <= `HDCR_DEV_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata_o = s_q.rdata;
  assign string_write_unlock_o = s_q.str_unlock;
  assign serial_string_unlock_o = s_q.ser_unlock;
  assign link_lpm_allow_o = s_q.lpm_allow;
  assign port_power_out_o = s_q.pwr_out;
  assign overcurrent_report_o = s_q.oc_rep;
  assign charge_port_en_o = s_q.chg_out;
  assign port_removable_o = s_q.rmbl_out;
  assign strap_ready_o = s_q.ready;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_rsvd_one;
    @(posedge clk_i) disable iff (rst_i) s_q.dev_cfg[4] && !s_q.dev_cfg[0];
  endproperty
  a_rsvd_one: assert property (p_rsvd_one) else $error("fixed device config bits wrong");

  property p_charge_rsvd;
    @(posedge clk_i) disable iff (rst_i) s_q.charge[7:2] == 6'h00;
  endproperty
  a_charge_rsvd: assert property (p_charge_rsvd) else $error("charge reserved bits set");

  property p_strap_capture;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.phase == HDCR_SETTLE && s_q.settle == 4'h0) |=>
        s_q.dev_cfg[3] == $past(shared_sync) && s_q.dev_cfg[2] == $past(pm_sync);
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

  property p_charge_capture;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.phase == HDCR_SETTLE && s_q.settle == 4'h0) |=> s_q.charge[1:0] == $past(chg_sync);
  endproperty
  a_charge_capture: assert property (p_charge_capture) else $error("charge pins missed");

  property p_lpm_block;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.dev_cfg[5] && !s_q.lpm_forced) |=> !link_lpm_allow_o;
  endproperty
  a_lpm_block: assert property (p_lpm_block) else $error("U1/U2 allowed while disabled");

  property p_lpm_forced;
    @(posedge clk_i) disable iff (rst_i)
      force_lpm_accept_i |=> ##1 link_lpm_allow_o;
  endproperty
  a_lpm_forced: assert property (p_lpm_forced) else $error("forced accept ignored");

  property p_pm_off;
    @(posedge clk_i) disable iff (rst_i)
      s_q.dev_cfg[2] |=> (port_power_out_o == 2'b00 && overcurrent_report_o == 2'b00);
  endproperty
  a_pm_off: assert property (p_pm_off) else $error("switching while management off");

  property p_shared;
    @(posedge clk_i) disable iff (rst_i)
      (!s_q.dev_cfg[2] && s_q.dev_cfg[3]) |=> !port_power_out_o[1];
  endproperty
  a_shared: assert property (p_shared) else $error("port 2 output used when shared");

  property p_rmbl_lock;
    @(posedge clk_i) disable iff (rst_i)
      !s_q.rmbl[7] |=> s_q.rmbl[1:0] == $past(s_q.rmbl[1:0]);
  endproperty
  a_rmbl_lock: assert property (p_rmbl_lock) else $error("removable bits changed when locked");

  property p_charge_out;
    @(posedge clk_i) disable iff (rst_i) ##1 charge_port_en_o == $past(s_q.charge[1:0]);
  endproperty
  a_charge_out: assert property (p_charge_out) else $error("charge enable mismatch");

  property p_unlock;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (string_write_unlock_o == $past(s_q.dev_cfg[`HDCR_BIT_STR_UNLOCK]) &&
           serial_string_unlock_o == $past(s_q.dev_cfg[`HDCR_BIT_SER_UNLOCK]));
  endproperty
  a_unlock: assert property (p_unlock) else $error("string unlock outputs wrong");

  property p_refused;
    @(posedge clk_i) disable iff (rst_i)
      (cfg_wr_i && !eeprom_mode_i && !smbus_mode_i && s_q.phase == HDCR_RUN) |=>
        ($stable(s_q.dev_cfg) && $stable(s_q.charge) && $stable(s_q.rmbl));
  endproperty
  a_refused: assert property (p_refused) else $error("write taken outside config mode");

  property p_dev_wr;
    @(posedge clk_i) disable iff (rst_i)
      (host_wr && cfg_addr_i == `HDCR_OFF_DEV_CFG) |=>
        s_q.dev_cfg == (($past(cfg_wdata_i) & `HDCR_DEV_CFG_WMASK) | 8'h10);
  endproperty
  a_dev_wr: assert property (p_dev_wr) else $error("device config write mask wrong");

  property p_rmbl_default;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.phase == HDCR_RUN && !s_q.rmbl[`HDCR_BIT_RMBL_OVR]) |=> port_removable_o == ~FACTORY_FIXED;
  endproperty
  a_rmbl_default: assert property (p_rmbl_default) else $error("removable default wrong");

  c_run: cover property (@(posedge clk_i) disable iff (rst_i) strap_ready_o);
  c_wr_cfg: cover property (@(posedge clk_i) disable iff (rst_i)
    host_wr && cfg_addr_i == `HDCR_OFF_DEV_CFG);
  c_forced: cover property (@(posedge clk_i) disable iff (rst_i) s_q.lpm_forced && s_q.dev_cfg[5]);
  c_shared: cover property (@(posedge clk_i) disable iff (rst_i)
    !s_q.dev_cfg[2] && s_q.dev_cfg[3] && |port_power_req_i);
  c_rmbl_open: cover property (@(posedge clk_i) disable iff (rst_i)
    host_wr && cfg_addr_i == `HDCR_OFF_RMBL && s_q.rmbl[7]);
endmodule
`default_nettype wire

// >>> testbench/hdcr_cfg_host.sv
// Behavioural EEPROM loader / SMBus host that writes the configuration bytes
`default_nettype none
module hdcr_cfg_host (
  input wire logic clk_i,
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [7:0] cfg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end
  // One-cycle strobe; released lines are scrambled so stale values never look valid
  task automatic write(input logic [7:0] addr, input logic [7:0] data, input int slow);
    repeat (slow) @(posedge clk_i);
    cfg_wr_o <= 1'b1;
    cfg_addr_o <= addr;
    cfg_wdata_o <= data;
    @(posedge clk_i);
    cfg_wr_o <= 1'b0;
    cfg_addr_o <= ~addr;
    cfg_wdata_o <= ~data;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench of the hub configuration register bank
`default_nettype none
`include "hdcr_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, shr = 1'b1, pm = 1'b0;
  logic eep = 1'b0, smb = 1'b0, frc = 1'b0, dis = 1'b0;
  logic [1:0] chg = 2'b10, req = 2'b00, oc = 2'b00, pwr, ocr, cpe, rmb;
  logic [7:0] ra = 8'h00, rd;
  logic wr, su, ssu, lpm, rdy;
  logic [7:0] wa, wd;
  int fails = 0, tests_run = 0;
  hdcr_cfg_host host_u (.clk_i(clk_i), .cfg_wr_o(wr), .cfg_addr_o(wa), .cfg_wdata_o(wd));
  hdcr_regs #(.FACTORY_FIXED(2'b00)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .shared_power_strap_i(shr), .power_mgmt_strap_i(pm), .charge_enable_pin_i(chg),
    .eeprom_mode_i(eep), .smbus_mode_i(smb), .cfg_wr_i(wr), .cfg_addr_i(wa),
    .cfg_wdata_i(wd), .cfg_addr_rd_i(ra), .force_lpm_accept_i(frc),
    .upstream_disconnect_i(dis), .port_power_req_i(req), .overcurrent_i(oc),
    .cfg_rdata_o(rd), .string_write_unlock_o(su), .serial_string_unlock_o(ssu),
    .link_lpm_allow_o(lpm), .port_power_out_o(pwr), .overcurrent_report_o(ocr),
    .charge_port_en_o(cpe), .port_removable_o(rmb), .strap_ready_o(rdy));
  initial forever #5 clk_i = ~clk_i;
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data lags the address by a registered stage
  task automatic check_rd(input logic [7:0] a, input logic [7:0] exp);
    ra <= a;
    repeat (2) @(posedge clk_i);
    #1 check(rd, exp);
    @(posedge clk_i);
  endtask
  // Both end on a rising edge so the next drive lands on an edge; outputs read
  // there were launched at least one edge earlier and are settled
  task automatic put(input logic [7:0] a, input logic [7:0] d, input int slow);
    host_u.write(a, d, slow);
    repeat (3) @(posedge clk_i);
  endtask
  // Five edges cover the two-flop overcurrent synchroniser plus the output stage
  task automatic settle;
    repeat (5) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_straps;
    check_rd(`HDCR_OFF_DEV_CFG, 8'h18);
    check_rd(`HDCR_OFF_CHARGE, 8'h02);
    check({6'h00, cpe}, 8'h02);
    check_rd(`HDCR_OFF_RMBL, 8'h03);
    check({6'h00, su, ssu}, 8'h00);
    check({7'h00, lpm}, 8'h01);
    put(`HDCR_OFF_DEV_CFG, 8'he0, 0);
    check_rd(`HDCR_OFF_DEV_CFG, 8'h18);
    $display("test straps done");
  endtask
  task automatic t_cfg;
    smb <= 1'b1;
    req <= 2'b11;
    oc <= 2'b11;
    put(`HDCR_OFF_DEV_CFG, 8'hfd, 0);
    check_rd(`HDCR_OFF_DEV_CFG, 8'hfc);
    check({6'h00, su, ssu}, 8'h03);
    check({7'h00, lpm}, 8'h00);
    check({4'h0, pwr, ocr}, 8'h00);
    frc <= 1'b1;
    @(posedge clk_i) frc <= 1'b0;
    settle();
    check({7'h00, lpm}, 8'h01);
    dis <= 1'b1;
    @(posedge clk_i) dis <= 1'b0;
    settle();
    check({7'h00, lpm}, 8'h00);
    $display("test device config done");
  endtask
  // Loader mode: shared then per-port switching
  task automatic t_power;
    smb <= 1'b0;
    eep <= 1'b1;
    req <= 2'b10;
    oc <= 2'b00;
    put(`HDCR_OFF_DEV_CFG, 8'h08, 3);
    check({6'h00, pwr}, 8'h01);
    oc <= 2'b10;
    settle();
    check({6'h00, ocr}, 8'h03);
    oc <= 2'b00;
    put(`HDCR_OFF_DEV_CFG, 8'h00, 0);
    check({6'h00, pwr}, 8'h02);
    oc <= 2'b01;
    settle();
    check({6'h00, ocr}, 8'h01);
    $display("test power switching done");
  endtask
  task automatic t_charge_rmbl;
    put(`HDCR_OFF_CHARGE, 8'hff, 0);
    check_rd(`HDCR_OFF_CHARGE, 8'h03);
    check({6'h00, cpe}, 8'h03);
    eep <= 1'b0;
    put(`HDCR_OFF_CHARGE, 8'h00, 1);
    check_rd(`HDCR_OFF_CHARGE, 8'h03);
    smb <= 1'b1;
    put(`HDCR_OFF_RMBL, 8'h00, 0);
    check_rd(`HDCR_OFF_RMBL, 8'h03);
    put(`HDCR_OFF_RMBL, 8'h81, 0);
    check_rd(`HDCR_OFF_RMBL, 8'h80);
    put(`HDCR_OFF_RMBL, 8'h81, 0);
    check_rd(`HDCR_OFF_RMBL, 8'h81);
    check({6'h00, rmb}, 8'h01);
    check_rd(8'h20, 8'h00);
    $display("test charge and removable done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200us;
    fails++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk_i);
    check({7'h00, rdy}, 8'h01);
    @(posedge clk_i);
    t_straps();
    t_cfg();
    t_power();
    t_charge_rmbl();
    conclude();
  end
endmodule
`default_nettype wire
